// *** rtl/tar_bank.sv ***
/*
 * control register three, limits, results, id and interrupt gating
 * assumes a sequencer that reports one finished channel per cycle,
 * and a host bus master with one-cycle strobes
 */
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module tar_bank
	import tar_pkg::*;
#(
	parameter logic [3:0] REVISION = 4'h1, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h5A // arbitrary value
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	input wire logic GPIO_FUNC_EN,
	input wire logic GPIO_EVENT,
	input wire tar_result_s RESULT_IN,
	output logic [TAR_NCH-1:0] SEQ_CHAN_EN,
	output logic ALERT_IRQ
);
	initial begin
		if (REVISION > 4'hF) begin
			$error("revision does not fit its field");
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	tar_bus_s bus;
	logic [15:0] ctrl3_ff;
	logic [15:0] mon_hi_ff, mon_lo_ff, thm_hi_ff, thm_lo_ff;
	logic [15:0] res_ff [0:5];
	logic [TAR_IRQ_W-1:0] irq_stat_ff, irq_en_ff, nxt_irq_stat;
	logic [15:0] rdata_ff;
	logic irq_ff;
	logic [TAR_NCH-1:0] seq_en_ff, nxt_seq_en;
	logic is_mon, is_thm, mon_lo_v, mon_hi_v, thm_lo_v, thm_hi_v;
	logic [TAR_IRQ_W-1:0] ev;

	assign bus = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

	function automatic logic hit(input tar_bus_s b, input logic [3:0] a);
		return b.wr && (b.addr == a);
	endfunction

	assign is_mon = RESULT_IN.valid && (RESULT_IN.chan == TAR_CH_AUX ||
		RESULT_IN.chan == TAR_CH_BAT);
	assign is_thm = RESULT_IN.valid && (RESULT_IN.chan == TAR_CH_THM);
	assign mon_lo_v = RESULT_IN.data < mon_lo_ff;
	assign mon_hi_v = RESULT_IN.data > mon_hi_ff;
	assign thm_lo_v = RESULT_IN.data < thm_lo_ff;
	assign thm_hi_v = RESULT_IN.data > thm_hi_ff;

	// ---------------------------------------------------------------
	// control register three
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ctrl3_ff <= TAR_CTRL3_RST;
		end else begin
			if (hit(bus, TAR_ADDR_CTRL3)) begin
				ctrl3_ff <= (bus.wdata & TAR_CTRL3_WMASK) | (ctrl3_ff & ~TAR_CTRL3_WMASK);
			end
			// flags are hardware owned; a monitor or thermal conversion overwrites its own pair
			if (is_mon) begin
				ctrl3_ff[TAR_B_MON_LOW] <= mon_lo_v;
				ctrl3_ff[TAR_B_MON_HIGH] <= mon_hi_v;
			end
			if (is_thm) begin
				ctrl3_ff[TAR_B_THM_LOW] <= thm_lo_v;
				ctrl3_ff[TAR_B_THM_HIGH] <= thm_hi_v;
			end
		end
	end

	// ---------------------------------------------------------------
	// limit registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			mon_hi_ff <= TAR_LIMIT_RST;
			mon_lo_ff <= TAR_LIMIT_RST;
			thm_hi_ff <= TAR_LIMIT_RST;
			thm_lo_ff <= TAR_LIMIT_RST;
		end else begin
			if (hit(bus, TAR_ADDR_MON_HI)) begin
				mon_hi_ff <= bus.wdata;
			end
			if (hit(bus, TAR_ADDR_MON_LO)) begin
				mon_lo_ff <= bus.wdata;
			end
			if (hit(bus, TAR_ADDR_THM_HI)) begin
				thm_hi_ff <= bus.wdata;
			end
			if (hit(bus, TAR_ADDR_THM_LO)) begin
				thm_lo_ff <= bus.wdata;
			end
		end
	end

	// ---------------------------------------------------------------
	// result registers
	// ---------------------------------------------------------------
	// aux and battery both map to slot 4, thermal to slot 5
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_res
			always_ff @(posedge CLK_SYS or negedge RST_B) begin
				if (!RST_B) begin
					res_ff[gi] <= TAR_RESULT_RST;
				end else if (RESULT_IN.valid) begin
					if (gi < 4 && RESULT_IN.chan == tar_chan_e'(gi)) begin
						res_ff[gi] <= RESULT_IN.data;
					end else if (gi == 4 && is_mon) begin
						res_ff[gi] <= RESULT_IN.data;
					end else if (gi == 5 && is_thm) begin
						res_ff[gi] <= RESULT_IN.data;
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// sequence enables
	// ---------------------------------------------------------------
	always_comb begin
		nxt_seq_en = {ctrl3_ff[TAR_B_EN_THM], ctrl3_ff[TAR_B_EN_BAT], ctrl3_ff[TAR_B_EN_AUX],
			ctrl3_ff[TAR_B_EN_PR2], ctrl3_ff[TAR_B_EN_PR1], ctrl3_ff[TAR_B_EN_HORZ],
			ctrl3_ff[TAR_B_EN_VERT]};
		if (GPIO_FUNC_EN) begin
			nxt_seq_en[TAR_CH_AUX] = 1'b0;
			nxt_seq_en[TAR_CH_BAT] = 1'b0;
		end else if (nxt_seq_en[TAR_CH_AUX] && nxt_seq_en[TAR_CH_BAT]) begin
			nxt_seq_en[TAR_CH_AUX] = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			seq_en_ff <= '0;
		end else begin
			seq_en_ff <= nxt_seq_en;
		end
	end
	assign SEQ_CHAN_EN = seq_en_ff;

	// ---------------------------------------------------------------
	// interrupt events and status
	// ---------------------------------------------------------------
	// data mode: any unmasked result; alert mode: only limit and pin events
	always_comb begin
		ev = '0;
		if (!ctrl3_ff[TAR_B_ALERT_MODE]) begin
			ev[TAR_I_DATA] = RESULT_IN.valid && !(is_thm && ctrl3_ff[TAR_B_THM_MASK]) &&
				!(is_mon && ctrl3_ff[TAR_B_MON_MASK]);
		end else begin
			ev[TAR_I_MON_LIM] = is_mon && !ctrl3_ff[TAR_B_MON_MASK] &&
				(mon_lo_v || mon_hi_v);
			ev[TAR_I_THM_LIM] = is_thm && !ctrl3_ff[TAR_B_THM_MASK] &&
				(thm_lo_v || thm_hi_v);
			ev[TAR_I_GPIO] = GPIO_EVENT && !ctrl3_ff[TAR_B_GPIO_MASK];
		end
	end

	always_comb begin
		nxt_irq_stat = irq_stat_ff;
		if (hit(bus, TAR_ADDR_IRQ_CLR)) begin
			nxt_irq_stat = irq_stat_ff & ~bus.wdata[TAR_IRQ_W-1:0];
		end
		nxt_irq_stat = nxt_irq_stat | ev; // set wins over clear
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			irq_stat_ff <= '0;
			irq_en_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			if (hit(bus, TAR_ADDR_IRQ_EN)) begin
				irq_en_ff <= bus.wdata[TAR_IRQ_W-1:0];
			end
			irq_ff <= |(nxt_irq_stat & irq_en_ff);
		end
	end
	assign ALERT_IRQ = irq_ff;

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rdata_ff <= TAR_ZERO16;
		end else if (bus.rd) begin
			unique case (bus.addr)
				TAR_ADDR_CTRL3: rdata_ff <= ctrl3_ff;
				TAR_ADDR_MON_HI: rdata_ff <= mon_hi_ff;
				TAR_ADDR_MON_LO: rdata_ff <= mon_lo_ff;
				TAR_ADDR_THM_HI: rdata_ff <= thm_hi_ff;
				TAR_ADDR_THM_LO: rdata_ff <= thm_lo_ff;
				TAR_ADDR_RES_VERT: rdata_ff <= res_ff[0];
				TAR_ADDR_RES_HORZ: rdata_ff <= res_ff[1];
				TAR_ADDR_RES_PR1: rdata_ff <= res_ff[2];
				TAR_ADDR_RES_PR2: rdata_ff <= res_ff[3];
				TAR_ADDR_RES_MON: rdata_ff <= res_ff[4];
				TAR_ADDR_RES_THM: rdata_ff <= res_ff[5];
				TAR_ADDR_ID: rdata_ff <= {4'h0, REVISION, DEVICE_ID};
				TAR_ADDR_IRQ_STAT: rdata_ff <= {12'h000, irq_stat_ff};
				TAR_ADDR_IRQ_EN: rdata_ff <= {12'h000, irq_en_ff};
				default: rdata_ff <= TAR_ZERO16;
			endcase
		end else begin
			rdata_ff <= TAR_ZERO16;
		end
	end
	assign REG_RDATA = rdata_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_thm_mask_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		is_thm && ctrl3_ff[TAR_B_THM_MASK] |-> !ev[TAR_I_DATA] && !ev[TAR_I_THM_LIM])
		else $error("masked thermal result raised an event");
	a_mon_mask_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		is_mon && ctrl3_ff[TAR_B_MON_MASK] |-> !ev[TAR_I_DATA] && !ev[TAR_I_MON_LIM])
		else $error("masked monitor result raised an event");
	a_mode_alert_only: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl3_ff[TAR_B_ALERT_MODE] |-> !ev[TAR_I_DATA])
		else $error("data event in alert mode");
	a_gpio_mask: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl3_ff[TAR_B_GPIO_MASK] |-> !ev[TAR_I_GPIO])
		else $error("masked pin raised alert");
	a_mon_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		is_mon && !hit(bus, TAR_ADDR_CTRL3) |=> ctrl3_ff[TAR_B_MON_LOW] == $past(mon_lo_v)
		&& ctrl3_ff[TAR_B_MON_HIGH] == $past(mon_hi_v))
		else $error("monitor limit flags wrong");
	a_thm_flags: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		is_thm && !hit(bus, TAR_ADDR_CTRL3) |=> ctrl3_ff[TAR_B_THM_LOW] == $past(thm_lo_v)
		&& ctrl3_ff[TAR_B_THM_HIGH] == $past(thm_hi_v))
		else $error("thermal limit flags wrong");
	a_gpio_skips: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		GPIO_FUNC_EN |=> !SEQ_CHAN_EN[TAR_CH_AUX] && !SEQ_CHAN_EN[TAR_CH_BAT])
		else $error("aux or battery enabled with pin function");
	a_aux_dropped: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!GPIO_FUNC_EN && ctrl3_ff[TAR_B_EN_AUX] && ctrl3_ff[TAR_B_EN_BAT]
		|=> SEQ_CHAN_EN[TAR_CH_BAT] && !SEQ_CHAN_EN[TAR_CH_AUX])
		else $error("aux not dropped in favour of battery");
	a_limit_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		hit(bus, TAR_ADDR_THM_HI) |=> thm_hi_ff == $past(bus.wdata))
		else $error("limit write lost");
	a_id_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		bus.rd && bus.addr == TAR_ADDR_ID |=> REG_RDATA[15:12] == 4'h0
		&& REG_RDATA[11:8] == REVISION && REG_RDATA[7:0] == DEVICE_ID)
		else $error("id read wrong");

	// ---------------------------------------------------------------
	// checks on reset, registers and the read port
	// ---------------------------------------------------------------
	// no disable here: these must hold on every edge while reset is low
	a_reset_values: assert property (@(posedge CLK_SYS)
		!RST_B |-> ctrl3_ff == TAR_CTRL3_RST && seq_en_ff == '0 && irq_ff == 1'b0
		&& mon_hi_ff == TAR_LIMIT_RST && mon_lo_ff == TAR_LIMIT_RST
		&& thm_hi_ff == TAR_LIMIT_RST && thm_lo_ff == TAR_LIMIT_RST
		&& rdata_ff == TAR_ZERO16)
		else $error("register not at reset value");
	a_results_reset: assert property (@(posedge CLK_SYS)
		!RST_B |-> res_ff[0] == TAR_RESULT_RST && res_ff[1] == TAR_RESULT_RST
		&& res_ff[2] == TAR_RESULT_RST && res_ff[3] == TAR_RESULT_RST
		&& res_ff[4] == TAR_RESULT_RST && res_ff[5] == TAR_RESULT_RST)
		else $error("result register not cleared by reset");
	a_ctrl3_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		hit(bus, TAR_ADDR_CTRL3) |=> (ctrl3_ff & TAR_CTRL3_WMASK)
		== ($past(bus.wdata) & TAR_CTRL3_WMASK))
		else $error("control register three write lost");
	// the bit below the thermal enable is the unused one
	a_unused_bit: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl3_ff[TAR_B_EN_THM-1] == 1'b0)
		else $error("unused control bit set");
	a_limit_mon_hi: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		hit(bus, TAR_ADDR_MON_HI) |=> mon_hi_ff == $past(bus.wdata))
		else $error("monitor high limit write lost");
	a_limit_mon_lo: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		hit(bus, TAR_ADDR_MON_LO) |=> mon_lo_ff == $past(bus.wdata))
		else $error("monitor low limit write lost");
	a_limit_thm_lo: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		hit(bus, TAR_ADDR_THM_LO) |=> thm_lo_ff == $past(bus.wdata))
		else $error("thermal low limit write lost");
	a_limit_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		bus.rd && bus.addr == TAR_ADDR_THM_LO |=> REG_RDATA == $past(thm_lo_ff))
		else $error("limit read wrong");
	a_result_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		bus.rd && bus.addr == TAR_ADDR_RES_VERT |=> REG_RDATA == $past(res_ff[0]))
		else $error("vertical result read wrong");
	a_mon_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		bus.rd && bus.addr == TAR_ADDR_RES_MON |=> REG_RDATA == $past(res_ff[4]))
		else $error("monitor result read wrong");
	a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!bus.rd |=> REG_RDATA == TAR_ZERO16)
		else $error("read data outside its cycle");
	a_results_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!RESULT_IN.valid |=> $stable(res_ff[0]) && $stable(res_ff[1])
		&& $stable(res_ff[2]) && $stable(res_ff[3])
		&& $stable(res_ff[4]) && $stable(res_ff[5]))
		else $error("result register changed with no conversion");

	// ---------------------------------------------------------------
	// checks on results, flags, channel enables and the interrupt
	// ---------------------------------------------------------------
	a_res_vert: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		RESULT_IN.valid && RESULT_IN.chan == TAR_CH_VERT |=> res_ff[0] == $past(RESULT_IN.data))
		else $error("vertical result not stored");
	a_res_horz: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		RESULT_IN.valid && RESULT_IN.chan == TAR_CH_HORZ |=> res_ff[1] == $past(RESULT_IN.data))
		else $error("horizontal result not stored");
	a_res_pr1: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		RESULT_IN.valid && RESULT_IN.chan == TAR_CH_PR1 |=> res_ff[2] == $past(RESULT_IN.data))
		else $error("first pressure result not stored");
	a_res_pr2: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		RESULT_IN.valid && RESULT_IN.chan == TAR_CH_PR2 |=> res_ff[3] == $past(RESULT_IN.data))
		else $error("second pressure result not stored");
	a_res_mon: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		is_mon |=> res_ff[4] == $past(RESULT_IN.data))
		else $error("monitor result not stored");
	a_res_thm: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		is_thm |=> res_ff[5] == $past(RESULT_IN.data))
		else $error("thermal result not stored");
	a_mon_flags_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!is_mon |=> ctrl3_ff[TAR_B_MON_LOW] == $past(ctrl3_ff[TAR_B_MON_LOW])
		&& ctrl3_ff[TAR_B_MON_HIGH] == $past(ctrl3_ff[TAR_B_MON_HIGH]))
		else $error("monitor flags changed with no conversion");
	a_thm_flags_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!is_thm |=> ctrl3_ff[TAR_B_THM_LOW] == $past(ctrl3_ff[TAR_B_THM_LOW])
		&& ctrl3_ff[TAR_B_THM_HIGH] == $past(ctrl3_ff[TAR_B_THM_HIGH]))
		else $error("thermal flags changed with no conversion");
	a_seq_map: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		1'b1 |=> SEQ_CHAN_EN[TAR_CH_VERT] == $past(ctrl3_ff[TAR_B_EN_VERT])
		&& SEQ_CHAN_EN[TAR_CH_HORZ] == $past(ctrl3_ff[TAR_B_EN_HORZ])
		&& SEQ_CHAN_EN[TAR_CH_PR1] == $past(ctrl3_ff[TAR_B_EN_PR1])
		&& SEQ_CHAN_EN[TAR_CH_PR2] == $past(ctrl3_ff[TAR_B_EN_PR2])
		&& SEQ_CHAN_EN[TAR_CH_THM] == $past(ctrl3_ff[TAR_B_EN_THM]))
		else $error("channel enable mapping wrong");
	a_data_event: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!ctrl3_ff[TAR_B_ALERT_MODE] && RESULT_IN.valid && !is_thm && !is_mon
		|-> ev[TAR_I_DATA])
		else $error("data event missing");
	a_thm_alert: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl3_ff[TAR_B_ALERT_MODE] && is_thm && !ctrl3_ff[TAR_B_THM_MASK]
		&& (thm_lo_v || thm_hi_v) |-> ev[TAR_I_THM_LIM])
		else $error("thermal alert missing");
	a_mon_alert: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl3_ff[TAR_B_ALERT_MODE] && is_mon && !ctrl3_ff[TAR_B_MON_MASK]
		&& (mon_lo_v || mon_hi_v) |-> ev[TAR_I_MON_LIM])
		else $error("monitor alert missing");
	a_gpio_alert: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ctrl3_ff[TAR_B_ALERT_MODE] && GPIO_EVENT && !ctrl3_ff[TAR_B_GPIO_MASK]
		|-> ev[TAR_I_GPIO])
		else $error("pin alert missing");
	a_set_wins: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ev != '0 |=> (irq_stat_ff & $past(ev)) == $past(ev))
		else $error("event lost in status");
	a_clear_works: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		hit(bus, TAR_ADDR_IRQ_CLR) && ev == '0
		|=> (irq_stat_ff & $past(bus.wdata[TAR_IRQ_W-1:0])) == '0)
		else $error("status clear lost");
	a_stat_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!hit(bus, TAR_ADDR_IRQ_CLR)
		|=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
		else $error("status bit dropped without clear");
	a_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		1'b1 |=> ALERT_IRQ == |(irq_stat_ff & $past(irq_en_ff)))
		else $error("interrupt level wrong");
endmodule

// *** rtl/tar_pkg.sv ***
/*
 * constants and carrier types for the alert, limit, result and id register bank
 * assumes a plain synchronous register port and a sequencer delivering results
 */
package tar_pkg;
	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [3:0] TAR_ADDR_CTRL3 = 4'h3;
	localparam logic [3:0] TAR_ADDR_MON_HI = 4'h4;
	localparam logic [3:0] TAR_ADDR_MON_LO = 4'h5;
	localparam logic [3:0] TAR_ADDR_THM_HI = 4'h6;
	localparam logic [3:0] TAR_ADDR_THM_LO = 4'h7;
	localparam logic [3:0] TAR_ADDR_RES_VERT = 4'h8;
	localparam logic [3:0] TAR_ADDR_RES_HORZ = 4'h9;
	localparam logic [3:0] TAR_ADDR_RES_PR1 = 4'hA;
	localparam logic [3:0] TAR_ADDR_RES_PR2 = 4'hB;
	localparam logic [3:0] TAR_ADDR_RES_MON = 4'hC;
	localparam logic [3:0] TAR_ADDR_RES_THM = 4'hD;
	localparam logic [3:0] TAR_ADDR_ID = 4'hE;
	localparam logic [3:0] TAR_ADDR_IRQ_STAT = 4'hF;
	localparam logic [3:0] TAR_ADDR_IRQ_EN = 4'h1;
	localparam logic [3:0] TAR_ADDR_IRQ_CLR = 4'h2;
	// ---------------------------------------------------------------
	// control register three fields
	// ---------------------------------------------------------------
	localparam int TAR_B_THM_MASK = 15;
	localparam int TAR_B_MON_MASK = 14;
	localparam int TAR_B_ALERT_MODE = 13;
	localparam int TAR_B_GPIO_MASK = 12;
	localparam int TAR_B_MON_LOW = 11;
	localparam int TAR_B_MON_HIGH = 10;
	localparam int TAR_B_THM_LOW = 9;
	localparam int TAR_B_THM_HIGH = 8;
	localparam int TAR_B_EN_VERT = 7;
	localparam int TAR_B_EN_HORZ = 6;
	localparam int TAR_B_EN_PR1 = 5;
	localparam int TAR_B_EN_PR2 = 4;
	localparam int TAR_B_EN_AUX = 3;
	localparam int TAR_B_EN_BAT = 2;
	localparam int TAR_B_EN_THM = 1;
	localparam logic [15:0] TAR_CTRL3_RST = 16'h0000;
	localparam logic [15:0] TAR_CTRL3_WMASK = 16'hF0FE;
	localparam logic [15:0] TAR_LIMIT_RST = 16'h0000;
	localparam logic [15:0] TAR_RESULT_RST = 16'h0000;
	localparam logic [15:0] TAR_ZERO16 = 16'h0000;
	// ---------------------------------------------------------------
	// interrupt status bits
	// ---------------------------------------------------------------
	localparam int TAR_IRQ_W = 4;
	localparam int TAR_I_DATA = 0;
	localparam int TAR_I_MON_LIM = 1;
	localparam int TAR_I_THM_LIM = 2;
	localparam int TAR_I_GPIO = 3;
	localparam int TAR_NCH = 7;

	typedef enum logic [2:0] {
		TAR_CH_VERT = 3'b000,
		TAR_CH_HORZ = 3'b001,
		TAR_CH_PR1 = 3'b010,
		TAR_CH_PR2 = 3'b011,
		TAR_CH_AUX = 3'b100,
		TAR_CH_BAT = 3'b101,
		TAR_CH_THM = 3'b110,
		TAR_CH_NONE = 3'b111
	} tar_chan_e;

	typedef struct packed {
		logic valid;
		tar_chan_e chan;
		logic [15:0] data;
	} tar_result_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} tar_bus_s;
endpackage

// *** testbench/tar_seq_model.sv ***
/* conversion sequencer stand-in feeding finished results to the bank
 * assumes one request at a time from the bench, taken on the rising edge */
`timescale 1ns/100ps
module tar_seq_model
	import tar_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic go,
	input wire tar_chan_e go_chan,
	input wire logic [15:0] go_data,
	input wire logic [TAR_NCH-1:0] SEQ_CHAN_EN,
	output tar_result_s RESULT_IN
);
	// a channel the bank left out of the sequence is never converted
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			RESULT_IN <= '{1'b0, TAR_CH_NONE, 16'h0000};
		end else if (go && SEQ_CHAN_EN[go_chan]) begin
			RESULT_IN <= '{1'b1, go_chan, go_data};
		end else begin
			// idle data flips so nothing can lean on a stale value
			RESULT_IN <= '{1'b0, TAR_CH_NONE, ~RESULT_IN.data};
		end
	end
endmodule

// *** testbench/touch_adc_alert_limit_results_tb.sv ***
/* self-checking bench for the alert, limit, result and id register bank
 * assumes the sequencer model beside it and a 50 MHz system clock */
`timescale 1ns/100ps
module touch_adc_alert_limit_results_tb
	import tar_pkg::*;
;
	logic clk_sys, rst_b, reg_wr, reg_rd, gpio_func_en, gpio_event, go, alert_irq;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, go_data;
	logic [TAR_NCH-1:0] seq_chan_en;
	tar_chan_e go_chan;
	tar_result_s result_in;
	int error_cnt = 0;
	int checked = 0;
	localparam logic [3:0] REV = 4'h3; // arbitrary value
	localparam logic [7:0] DEV = 8'hC4; // arbitrary value
	localparam logic [3:0] RADR [7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hC, 4'hD};

	tar_bank #(.REVISION(REV), .DEVICE_ID(DEV)) tar_bank_i (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.GPIO_FUNC_EN(gpio_func_en), .GPIO_EVENT(gpio_event), .RESULT_IN(result_in),
		.SEQ_CHAN_EN(seq_chan_en), .ALERT_IRQ(alert_irq));
	tar_seq_model tar_seq_model_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .go(go),
		.go_chan(go_chan), .go_data(go_data), .SEQ_CHAN_EN(seq_chan_en),
		.RESULT_IN(result_in));

	// ---------------------------------------------------------------
	// bus and check tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("register %h", a), exp, reg_rdata);
	endtask
	task automatic res(input tar_chan_e c, input logic [15:0] d);
		@(posedge clk_sys);
		go <= 1'b1;
		go_chan <= c;
		go_data <= d;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// status read, level output, then a clear so the next case starts clean
	task automatic irq(input logic [3:0] st, input logic lvl);
		rd(TAR_ADDR_IRQ_STAT, {12'h000, st});
		chk("alert level", {15'h0000, lvl}, {15'h0000, alert_irq});
		wr(TAR_ADDR_IRQ_CLR, 16'h000F);
	endtask
	task automatic seq(input logic [15:0] c, input logic f, input logic [6:0] exp);
		@(posedge clk_sys);
		gpio_func_en <= f;
		wr(TAR_ADDR_CTRL3, c);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("channel enables", {9'h000, exp}, {9'h000, seq_chan_en});
	endtask
	task automatic pin_event();
		@(posedge clk_sys);
		gpio_event <= 1'b1;
		@(posedge clk_sys);
		gpio_event <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		for (int a = 3; a < 14; a++) rd(4'(a), TAR_ZERO16);
		rd(TAR_ADDR_ID, {4'h0, REV, DEV});
		@(posedge clk_sys);
		#1;
		chk("read data after its cycle", TAR_ZERO16, reg_rdata);
		rd(4'h0, TAR_ZERO16);
		chk("channel enables", 16'h0000, {9'h000, seq_chan_en});
	endtask
	task automatic t_regs();
		for (int a = 4; a < 8; a++) wr(4'(a), 16'(16'h1111 * a));
		for (int a = 4; a < 8; a++) rd(4'(a), 16'(16'h1111 * a));
		wr(TAR_ADDR_RES_VERT, 16'hBEEF);
		rd(TAR_ADDR_RES_VERT, TAR_RESULT_RST);
		wr(TAR_ADDR_ID, 16'hFFFF);
		rd(TAR_ADDR_ID, {4'h0, REV, DEV});
		wr(TAR_ADDR_CTRL3, 16'hFFFF);
		rd(TAR_ADDR_CTRL3, 16'hF0FE);
		wr(TAR_ADDR_IRQ_EN, 16'h000F);
		rd(TAR_ADDR_IRQ_EN, 16'h000F);
	endtask
	task automatic t_seq();
		seq(16'h00FE, 1'b0, 7'h6F);
		seq(16'h00FE, 1'b1, 7'h4F);
		seq(16'h0008, 1'b0, 7'h10);
		seq(16'h0004, 1'b0, 7'h20);
		seq(16'h0080, 1'b0, 7'h01);
	endtask
	task automatic t_results();
		wr(TAR_ADDR_MON_HI, 16'h0800);
		wr(TAR_ADDR_MON_LO, 16'h0100);
		wr(TAR_ADDR_THM_HI, 16'h0800);
		wr(TAR_ADDR_THM_LO, 16'h0100);
		seq(16'h20F6, 1'b0, 7'h6F);
		for (int c = 0; c < 7; c++) if (c != 4) res(tar_chan_e'(c), 16'(16'h0400 + c));
		for (int c = 0; c < 7; c++) if (c != 4) rd(RADR[c], 16'(16'h0400 + c));
		irq(4'h0, 1'b0);
		res(TAR_CH_THM, 16'h0900);
		rd(TAR_ADDR_CTRL3, 16'h21F6);
		irq(4'h4, 1'b1);
		res(TAR_CH_THM, 16'h0800);
		rd(TAR_ADDR_CTRL3, 16'h20F6);
		res(TAR_CH_THM, 16'h0050);
		rd(TAR_ADDR_CTRL3, 16'h22F6);
		irq(4'h4, 1'b1);
		res(TAR_CH_BAT, 16'h0900);
		rd(TAR_ADDR_CTRL3, 16'h26F6);
		irq(4'h2, 1'b1);
		res(TAR_CH_BAT, 16'h0050);
		rd(TAR_ADDR_CTRL3, 16'h2AF6);
		irq(4'h2, 1'b1);
	endtask
	task automatic t_masks();
		wr(TAR_ADDR_CTRL3, 16'hE0F6);
		res(TAR_CH_THM, 16'h0900);
		res(TAR_CH_BAT, 16'h0900);
		rd(TAR_ADDR_CTRL3, 16'hE5F6);
		irq(4'h0, 1'b0);
		wr(TAR_ADDR_CTRL3, 16'h20F6);
		pin_event();
		irq(4'h8, 1'b1);
		wr(TAR_ADDR_CTRL3, 16'h30F6);
		pin_event();
		irq(4'h0, 1'b0);
		wr(TAR_ADDR_CTRL3, 16'h00F6);
		pin_event();
		res(TAR_CH_THM, 16'h0900);
		irq(4'h1, 1'b1);
		wr(TAR_ADDR_CTRL3, 16'h80F6);
		res(TAR_CH_THM, 16'h0400);
		irq(4'h0, 1'b0);
		wr(TAR_ADDR_CTRL3, 16'h40F6);
		res(TAR_CH_BAT, 16'h0400);
		irq(4'h0, 1'b0);
		res(TAR_CH_VERT, 16'h0123);
		wr(TAR_ADDR_IRQ_EN, 16'h000E);
		rd(TAR_ADDR_IRQ_STAT, 16'h0001);
		chk("alert level", 16'h0000, {15'h0000, alert_irq});
		wr(TAR_ADDR_IRQ_EN, 16'h000F);
		irq(4'h1, 1'b1);
	endtask

	// ---------------------------------------------------------------
	// run control
	// ---------------------------------------------------------------
	task automatic finish_test();
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// whole run needs about 270 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		finish_test();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, gpio_func_en, gpio_event, go} = 6'b000000;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		go_data = 16'h0000;
		go_chan = TAR_CH_NONE;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_regs();
		t_seq();
		t_results();
		t_masks();
		finish_test();
	end
endmodule
